// ===== rtl/irs_pkg.sv
// Package for the interrupt, buffer status and receive length register block
package irs_pkg;

  // ==========================================================================
  // Register indices and APB address width
  // ==========================================================================
  localparam logic [7:0]  IRS_IDX_ENABLE_TWO  = 8'h36;
  localparam logic [7:0]  IRS_IDX_STATUS_TWO  = 8'h38;
  localparam logic [7:0]  IRS_IDX_FIFO_STATUS = 8'h39;
  localparam logic [7:0]  IRS_IDX_RXLEN_HIGH  = 8'h3a;
  localparam logic [7:0]  IRS_IDX_RXLEN_LOW   = 8'h3b;
  localparam logic [7:0]  IRS_IDX_EVT_STATUS  = 8'h40;
  localparam logic [7:0]  IRS_IDX_EVT_MASK    = 8'h41;
  localparam int unsigned IRS_ADDR_W          = 12;

  // ==========================================================================
  // Bit positions of the second interrupt status register
  // ==========================================================================
  localparam int unsigned IRS_BIT_ANA  = 7;
  localparam int unsigned IRS_BIT_CMD  = 6;
  localparam int unsigned IRS_BIT_CRC  = 2;
  localparam int unsigned IRS_BIT_LEN  = 1;
  localparam int unsigned IRS_BIT_PRE  = 0;
  localparam logic [7:0]  IRS_STATUS_TWO_USED = 8'hc7;

  // Bit positions of the receive length high register
  localparam int unsigned IRS_BIT_CRC_BYPASS = 7;
  localparam int unsigned IRS_BIT_DIRECT     = 6;
  localparam int unsigned IRS_BIT_REPEAT     = 5;
  localparam int unsigned IRS_BIT_AUTO_ERR   = 4;

  // Bit positions of the block event status and mask registers
  localparam int unsigned IRS_EVT_ERR_SUMMARY = 0;
  localparam int unsigned IRS_EVT_HDR_SECOND  = 1;
  localparam int unsigned IRS_EVT_REPEAT      = 2;
  localparam int unsigned IRS_EVT_OVERFLOW    = 3;
  localparam logic [3:0]  IRS_EVT_USED        = 4'hf;

  // ==========================================================================
  // Reset values, counts and command codes
  // ==========================================================================
  localparam logic [7:0]  IRS_RST_ENABLE_TWO  = 8'h40;
  localparam logic [7:0]  IRS_RST_ZERO8       = 8'h00;
  localparam logic [3:0]  IRS_RST_EVT_MASK    = 4'h0;
  localparam logic [4:0]  IRS_FIFO_DEPTH      = 5'h18;
  localparam logic [4:0]  IRS_FIFO_EMPTY_READ = 5'h1f;
  localparam logic [11:0] IRS_LEN_ERRCODE     = 12'h029;
  localparam logic [7:0]  IRS_LEN_SHORT16     = 8'h10;
  localparam logic [7:0]  IRS_LEN_SHORT32     = 8'h20;
  localparam logic [7:0]  IRS_CMD_SHORT_FIRST = 8'h98;
  localparam logic [7:0]  IRS_CMD_SHORT_LAST  = 8'h9c;
  localparam logic [7:0]  IRS_CMD_SHORT32     = 8'h9f;
  localparam logic [2:0]  IRS_BYTE_SECOND     = 3'h2;
  localparam logic [2:0]  IRS_BYTE_FOURTH     = 3'h4;
  localparam logic [2:0]  IRS_BYTE_SIXTH      = 3'h6;
  localparam logic [2:0]  IRS_BYTE_SAT        = 3'h7;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Single-cycle event pulses from the reader core, same clock
  typedef struct packed {
    logic cmd_done;
    logic crc_error;
    logic protocol_error;
    logic preamble_error;
    logic rx_end;
    logic header_bit;
    logic header_value;
    logic fifo_load;
    logic fifo_read;
    logic fifo_flush;
  } irs_core_evt_t;

  // Levels from the reader core, same clock
  typedef struct packed {
    logic tx_active;
    logic rx_active;
  } irs_core_lvl_t;

  // Analog status pins and chip enable, asynchronous
  typedef struct packed {
    logic chip_enable;
    logic field_present_good;
    logic pll_ok;
    logic osc_ok;
  } irs_pins_t;

endpackage

// ===== rtl/irs_regs.sv
// Interrupt status, buffer status and receive length registers behind an APB slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// ============================================================================
// ============================================================================
module irs_regs
  import irs_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [IRS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Reader core
  input  wire irs_core_evt_t         core_evt,
  input  wire irs_core_lvl_t         core_lvl,
  input  wire logic                  cmd_valid,
  input  wire logic [7:0]            cmd_code,
  input  wire logic [11:0]           rx_bit_count,
  input  wire logic                  first_irq_pending,
  // Asynchronous pins
  input  wire irs_pins_t             pins,
  // Outputs to the core and the host
  output logic                       irq,
  output logic                       error_summary,
  output logic                       crc_bypass,
  output logic                       direct_buffer_mode,
  output logic [11:0]                expected_rx_len
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic [3:0]  sync3_reg;
  logic [3:0]  stable_reg;
  logic [3:0]  stable_next;
  logic        en_low;
  logic        ana_change;

  logic [7:0]  status_two_reg;
  logic [7:0]  enable_two_reg;
  logic [3:0]  evt_status_reg;
  logic [3:0]  evt_mask_reg;
  logic [7:0]  rxlen_high_reg;
  logic [7:0]  rxlen_low_reg;
  logic        errcode_len_reg;
  logic [4:0]  byte_count_reg;
  logic        overflow_reg;
  logic        empty_read_reg;
  logic [2:0]  rx_bytes_reg;
  logic        rx_active_d_reg;

  logic        setup;
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  logic [7:0]  idx;
  logic [7:0]  acc_idx_reg;
  logic [7:0]  rd_byte;
  logic        mapped;
  logic [11:0] prog_len;
  logic [11:0] eff_len;
  logic        rx_start;
  logic        crc_err_ev;
  logic        len_err_ev;
  logic        pre_err_ev;
  logic        ovfl_ev;
  logic        empty_rd_ev;
  logic        rx_byte_ev;
  logic [2:0]  rx_bytes_next;
  logic        hdr_second_ev;
  logic        repeat_ev;
  logic [7:0]  set_two;
  logic [3:0]  set_evt;
  logic        short16_cmd;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Byte address to register index; word aligned, index is address over four
  function automatic logic [7:0] addr_to_idx(input logic [IRS_ADDR_W-1:0] a);
    addr_to_idx = a[9:2];
  endfunction

  // Index decode for the slave error answer; the read mux decodes the index in its own case
  function automatic logic idx_mapped(input logic [7:0] i);
    idx_mapped = (i == IRS_IDX_ENABLE_TWO) || (i == IRS_IDX_STATUS_TWO) ||
                 (i == IRS_IDX_FIFO_STATUS) || (i == IRS_IDX_RXLEN_HIGH) ||
                 (i == IRS_IDX_RXLEN_LOW) || (i == IRS_IDX_EVT_STATUS) ||
                 (i == IRS_IDX_EVT_MASK);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Three stages; a new level counts only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Filtered levels; bit 3 is chip enable
  always_comb
  begin
    stable_next = stable_reg;
    for (int i = 0; i < 4; i++)
    begin
      if (sync2_reg[i] == sync3_reg[i])
      begin
        stable_next[i] = sync3_reg[i];
      end
    end
  end

  // Starts at zero, so a good status seen after reset counts as a change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stable_reg <= 4'h0;
    end
    else
    begin
      stable_reg <= stable_next;
    end
  end

  assign en_low     = ~stable_reg[3];
  assign ana_change = |(stable_next[2:0] ^ stable_reg[2:0]);

  // ==========================================================================
  // APB decode
  // ==========================================================================
  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite;
  assign rd_done     = access_done & ~pwrite;
  assign idx         = addr_to_idx(paddr);
  assign mapped      = idx_mapped(idx);

  // ==========================================================================
  // Event sources
  // ==========================================================================
  assign rx_start      = core_lvl.rx_active & ~rx_active_d_reg;
  assign crc_err_ev    = core_evt.crc_error & ~rxlen_high_reg[IRS_BIT_CRC_BYPASS];
  assign prog_len      = {rxlen_high_reg[3:0], rxlen_low_reg};
  assign eff_len       = errcode_len_reg ? IRS_LEN_ERRCODE : prog_len;
  assign len_err_ev    = core_evt.protocol_error |
                         (core_evt.rx_end & (rx_bit_count < eff_len));
  assign ovfl_ev       = core_evt.fifo_load & ~core_evt.fifo_read &
                         (byte_count_reg >= IRS_FIFO_DEPTH);
  assign pre_err_ev    = core_evt.preamble_error | ovfl_ev;
  assign empty_rd_ev   = core_evt.fifo_read & ~core_evt.fifo_load & (byte_count_reg == 5'h00);
  assign rx_byte_ev    = core_evt.fifo_load & core_lvl.rx_active;
  assign rx_bytes_next = (rx_bytes_reg == IRS_BYTE_SAT) ? rx_bytes_reg : rx_bytes_reg + 3'h1;

  // Direct mode swaps the header interrupt for the second-byte one
  assign hdr_second_ev = rxlen_high_reg[IRS_BIT_DIRECT] ?
                         (rx_byte_ev & (rx_bytes_next == IRS_BYTE_SECOND)) :
                         (core_evt.header_bit & core_evt.header_value);
  assign repeat_ev     = rxlen_high_reg[IRS_BIT_REPEAT] & rx_byte_ev &
                         ((rx_bytes_next == IRS_BYTE_FOURTH) ||
                          (rx_bytes_next == IRS_BYTE_SIXTH));

  // Flags are set regardless of the enables
  always_comb
  begin
    set_two              = 8'h00;
    set_two[IRS_BIT_ANA] = ana_change;
    set_two[IRS_BIT_CMD] = core_evt.cmd_done;
    set_two[IRS_BIT_CRC] = crc_err_ev;
    set_two[IRS_BIT_LEN] = len_err_ev;
    set_two[IRS_BIT_PRE] = pre_err_ev;
  end

  always_comb
  begin
    set_evt                      = 4'h0;
    set_evt[IRS_EVT_ERR_SUMMARY] = crc_err_ev | len_err_ev | pre_err_ev;
    set_evt[IRS_EVT_HDR_SECOND]  = hdr_second_ev;
    set_evt[IRS_EVT_REPEAT]      = repeat_ev;
    set_evt[IRS_EVT_OVERFLOW]    = ovfl_ev;
  end

  // ==========================================================================
  // Second interrupt status register
  // ==========================================================================
  // A read clears only the bits it reported, so a set after the snapshot is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_two_reg <= IRS_RST_ZERO8;
    end
    else if (en_low)
    begin
      status_two_reg <= IRS_RST_ZERO8;
    end
    else if (rd_done && acc_idx_reg == IRS_IDX_STATUS_TWO)
    begin
      status_two_reg <= ((status_two_reg & ~prdata[7:0]) | set_two) & IRS_STATUS_TWO_USED;
    end
    else
    begin
      status_two_reg <= (status_two_reg | set_two) & IRS_STATUS_TWO_USED;
    end
  end

  // Enable register for the second status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_two_reg <= IRS_RST_ENABLE_TWO;
    end
    else if (wr_done && idx == IRS_IDX_ENABLE_TWO)
    begin
      enable_two_reg <= pwdata[7:0] & IRS_STATUS_TWO_USED;
    end
  end

  // ==========================================================================
  // Block event status and mask
  // ==========================================================================
  // Write one to clear; a simultaneous set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_status_reg <= 4'h0;
    end
    else if (wr_done && idx == IRS_IDX_EVT_STATUS)
    begin
      evt_status_reg <= (evt_status_reg & ~pwdata[3:0]) | set_evt;
    end
    else
    begin
      evt_status_reg <= evt_status_reg | set_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_mask_reg <= IRS_RST_EVT_MASK;
    end
    else if (wr_done && idx == IRS_IDX_EVT_MASK)
    begin
      evt_mask_reg <= pwdata[3:0] & IRS_EVT_USED;
    end
  end

  // ==========================================================================
  // Interrupt pin and summary pulse
  // ==========================================================================
  // Enables gate only the pin; one cycle of latency keeps the output a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq           <= 1'b0;
      error_summary <= 1'b0;
    end
    else
    begin
      irq           <= (|(status_two_reg & enable_two_reg)) |
                       (|(evt_status_reg & evt_mask_reg)) | first_irq_pending;
      error_summary <= set_evt[IRS_EVT_ERR_SUMMARY];
    end
  end

  // ==========================================================================
  // Receive length registers
  // ==========================================================================
  assign short16_cmd = (cmd_code >= IRS_CMD_SHORT_FIRST) && (cmd_code <= IRS_CMD_SHORT_LAST);

  // A short command preset takes priority over a host write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxlen_high_reg <= IRS_RST_ZERO8;
      rxlen_low_reg  <= IRS_RST_ZERO8;
    end
    else if (cmd_valid && (short16_cmd || cmd_code == IRS_CMD_SHORT32))
    begin
      rxlen_high_reg <= {rxlen_high_reg[7:4], 4'h0};
      rxlen_low_reg  <= short16_cmd ? IRS_LEN_SHORT16 : IRS_LEN_SHORT32;
    end
    else if (wr_done)
    begin
      if (idx == IRS_IDX_RXLEN_HIGH)
      begin
        rxlen_high_reg <= pwdata[7:0];
      end
      if (idx == IRS_IDX_RXLEN_LOW)
      begin
        rxlen_low_reg <= pwdata[7:0];
      end
    end
  end

  // Error-code length override lasts for one reception only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      errcode_len_reg <= 1'b0;
    end
    else if (rx_start)
    begin
      errcode_len_reg <= 1'b0;
    end
    else if (core_evt.header_bit && core_evt.header_value && rxlen_high_reg[IRS_BIT_AUTO_ERR])
    begin
      errcode_len_reg <= 1'b1;
    end
  end

  // Received byte counter for the second, fourth and sixth byte interrupts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_bytes_reg    <= 3'h0;
      rx_active_d_reg <= 1'b0;
    end
    else
    begin
      rx_active_d_reg <= core_lvl.rx_active;
      if (rx_start)
      begin
        rx_bytes_reg <= 3'h0;
      end
      else if (rx_byte_ev)
      begin
        rx_bytes_reg <= rx_bytes_next;
      end
    end
  end

  // Core-facing configuration and length, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_bypass         <= 1'b0;
      direct_buffer_mode <= 1'b0;
      expected_rx_len    <= 12'h000;
    end
    else
    begin
      crc_bypass         <= rxlen_high_reg[IRS_BIT_CRC_BYPASS];
      direct_buffer_mode <= rxlen_high_reg[IRS_BIT_DIRECT];
      expected_rx_len    <= eff_len;
    end
  end

  // ==========================================================================
  // Buffer fill tracking
  // ==========================================================================
  // Count saturates at the depth; overflow sticks until a flush, empty-read until a flush or a load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_count_reg <= 5'h00;
      overflow_reg   <= 1'b0;
      empty_read_reg <= 1'b0;
    end
    else if (core_evt.fifo_flush)
    begin
      byte_count_reg <= 5'h00;
      overflow_reg   <= 1'b0;
      empty_read_reg <= 1'b0;
    end
    else
    begin
      if (ovfl_ev)
      begin
        overflow_reg <= 1'b1;
      end
      if (empty_rd_ev)
      begin
        empty_read_reg <= 1'b1;
      end
      else if (core_evt.fifo_load)
      begin
        empty_read_reg <= 1'b0;
      end
      if (core_evt.fifo_load && !core_evt.fifo_read && byte_count_reg < IRS_FIFO_DEPTH)
      begin
        byte_count_reg <= byte_count_reg + 5'h01;
      end
      else if (core_evt.fifo_read && !core_evt.fifo_load && byte_count_reg != 5'h00)
      begin
        byte_count_reg <= byte_count_reg - 5'h01;
      end
    end
  end

  // ==========================================================================
  // APB read data and answer
  // ==========================================================================
  // Read mux; status is snapshot at setup, so a set during access survives the clear
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx)
      IRS_IDX_ENABLE_TWO:  rd_byte = enable_two_reg;
      IRS_IDX_STATUS_TWO:  rd_byte = status_two_reg;
      IRS_IDX_FIFO_STATUS: rd_byte = {core_lvl.tx_active, core_lvl.rx_active, overflow_reg,
                                      empty_read_reg ? IRS_FIFO_EMPTY_READ : byte_count_reg};
      IRS_IDX_RXLEN_HIGH:  rd_byte = rxlen_high_reg;
      IRS_IDX_RXLEN_LOW:   rd_byte = rxlen_low_reg;
      IRS_IDX_EVT_STATUS:  rd_byte = {4'h0, evt_status_reg};
      IRS_IDX_EVT_MASK:    rd_byte = {4'h0, evt_mask_reg};
      default:             rd_byte = 8'h00;
    endcase
  end

  // Answer one cycle after setup: access phase lasts exactly one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      acc_idx_reg <= 8'h00;
    end
    else if (setup)
    begin
      pready      <= 1'b1;
      pslverr     <= ~mapped;
      prdata      <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      acc_idx_reg <= idx;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ===== verification/irs_regs_asserts.sv
// Concurrent checks on the register block ports
`timescale 1ns/1ps
module irs_regs_asserts
  import irs_pkg::*;
(
  // Clock, reset and bus
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [IRS_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Core side and outputs
  input wire irs_core_evt_t         core_evt,
  input wire logic                  cmd_valid,
  input wire logic [7:0]            cmd_code,
  input wire logic                  first_irq_pending,
  input wire logic                  irq,
  input wire logic                  error_summary,
  input wire logic                  crc_bypass,
  input wire logic [11:0]           expected_rx_len
);
  // ==========================================================================
  // One clock domain, so one clocking and one disable
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing after setup");
  a_ready_access: assert property (pready |-> psel && penable && !$past(penable))
    else $error("pready outside first access cycle");
  a_error_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  a_reserved_zero: assert property (pready && !pwrite && paddr[9:2] == IRS_IDX_STATUS_TWO |-> prdata[5:3] == 3'h0)
    else $error("reserved status bits not zero");
  a_err_summary: assert property (core_evt.protocol_error || core_evt.preamble_error |=> error_summary)
    else $error("error summary pulse missing");
  a_irq_first: assert property (first_irq_pending |=> irq)
    else $error("irq low with first register pending");
  a_short_sixteen: assert property (cmd_valid && cmd_code inside {[8'h98:8'h9c]} |-> ##[1:3] expected_rx_len == 12'h010)
    else $error("short command length not 16");
  a_short_thirty: assert property (cmd_valid && cmd_code == 8'h9f |-> ##[1:3] expected_rx_len == 12'h020)
    else $error("short command length not 32");
  a_bypass_copy: assert property (pready && pwrite && paddr[9:2] == IRS_IDX_RXLEN_HIGH |-> ##2 crc_bypass == $past(pwdata[7], 2))
    else $error("crc bypass output not following register");
endmodule

// ===== verification/irs_host.sv
// Host model: APB master reaching the register block
`timescale 1ns/1ps
module irs_host
  import irs_pkg::*;
(
  // Bus clock
  input  wire logic                  pclk,
  // Request
  output logic                       psel,
  output logic                       penable,
  output logic                       pwrite,
  output logic [IRS_ADDR_W-1:0]      paddr,
  output logic [31:0]                pwdata,
  // Answer
  input  wire logic [31:0]           prdata,
  input  wire logic                  pready,
  input  wire logic                  pslverr
);
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One transfer, entered just after a rising edge; a lost pready yields unknown data and error
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] q, output logic e);
    // Let the release of the previous transfer settle for one cycle
    if (psel)
      @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready)
        break;
    end
    q = pready ? prdata : 'x;
    e = pready ? pslverr : 1'bx;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== verification/tb_irq_fifo_rxlen_status_regs.sv
// Self-checking bench for the interrupt, buffer status and receive length block
`timescale 1ns/1ps
module tb_irq_fifo_rxlen_status_regs;
  import irs_pkg::*;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel, penable, pwrite, pready, pslverr, irq, error_summary, crc_bypass, direct_buffer_mode;
  logic [IRS_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, q;
  irs_core_evt_t         core_evt = '0;
  irs_core_lvl_t         core_lvl = '0;
  irs_pins_t             pins = 4'hf;
  logic                  cmd_valid = 1'b0, first_irq_pending = 1'b0, e;
  logic [7:0]            cmd_code = 8'h00;
  logic [11:0]           rx_bit_count = 12'h000, expected_rx_len;
  int                    err_total = 0, n_checks = 0;
  always #2.5 pclk = ~pclk;
  irs_regs dut (.*);
  irs_host h (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      $display("Error %s expected %h seen %h", n, x, s);
      err_total++;
    end
  endtask
  // A bus that never answers ends the run as a failure
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    h.xfer(w, i, d, q, e);
    if (e === 1'bx)
    begin
      err_total++;
      close_out;
    end
  endtask
  task automatic rd(input logic [7:0] i);
    bus(1'b0, i, 8'h00);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  // Event bits: 200 done, 100 crc, 080 protocol, 040 preamble, 004 load, 002 read, 001 flush
  task automatic pulse(input irs_core_evt_t v);
    core_evt <= v;
    @(posedge pclk);
    core_evt <= '0;
    @(posedge pclk);
  endtask
  task automatic t_events;
    // Good levels arrive with chip enable, whose low phase still clears
    rd(IRS_IDX_STATUS_TWO);
    chk("status at enable", q, 32'h0);
    rd(IRS_IDX_STATUS_TWO);
    chk("status after read", q, 32'h0);
    pins.osc_ok <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(IRS_IDX_STATUS_TWO);
    chk("status after osc fall", q, 32'h80);
    pins.osc_ok <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(IRS_IDX_STATUS_TWO);
    chk("status after osc rise", q, 32'h80);
    pulse(10'h200);
    @(negedge pclk);
    chk("irq on done", irq, 1'b1);
    @(posedge pclk);
    rd(IRS_IDX_STATUS_TWO);
    chk("done flag", q, 32'h40);
    repeat (2) @(negedge pclk);
    chk("irq after read", irq, 1'b0);
    @(posedge pclk);
    // Sub-flags are disabled by default, so the pin must stay low
    for (int k = 0; k < 3; k++)
    begin
      pulse(10'h100 >> k);
      @(negedge pclk);
      chk("irq gated", irq, 1'b0);
      @(posedge pclk);
      rd(IRS_IDX_STATUS_TWO);
      chk("error flag", q, 32'h4 >> k);
    end
    first_irq_pending <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("irq from first register", irq, 1'b1);
    @(posedge pclk);
    first_irq_pending <= 1'b0;
    $display("events test done");
  endtask
  task automatic t_fifo;
    core_lvl <= 2'b10;
    repeat (25) pulse(10'h004);
    rd(IRS_IDX_FIFO_STATUS);
    chk("fifo full overflow", q, 32'hb8);
    rd(IRS_IDX_STATUS_TWO);
    chk("overflow error flag", q, 32'h01);
    pulse(10'h001);
    pulse(10'h002);
    core_lvl <= 2'b01;
    @(posedge pclk);
    rd(IRS_IDX_FIFO_STATUS);
    chk("empty read count", q, 32'h5f);
    $display("fifo test done");
  endtask
  task automatic t_length;
    wr(IRS_IDX_RXLEN_HIGH, 8'h8a);
    wr(IRS_IDX_RXLEN_LOW, 8'h5c);
    repeat (2) @(negedge pclk);
    chk("host length", expected_rx_len, 12'ha5c);
    chk("bypass output", crc_bypass, 1'b1);
    @(posedge pclk);
    for (logic [8:0] c = 9'h098; c <= 9'h09f; c++)
    begin
      wr(IRS_IDX_RXLEN_LOW, 8'h00);
      cmd_valid <= 1'b1;
      cmd_code <= c[7:0];
      @(posedge pclk);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge pclk);
      rd(IRS_IDX_RXLEN_LOW);
      chk("preset low", q, c == 9'h09f ? 32'h20 : (c <= 9'h09c ? 32'h10 : 32'h0));
    end
    rd(IRS_IDX_RXLEN_HIGH);
    chk("preset high", q, 32'h80);
    rd(8'h00);
    chk("unmapped error", e, 1'b1);
    $display("length test done");
  endtask
  // Direct mode, repeat interrupts, error-code length and short reception
  task automatic t_rx;
    wr(IRS_IDX_RXLEN_HIGH, 8'h70);
    wr(IRS_IDX_EVT_STATUS, 8'h0f);
    repeat (6) pulse(10'h004);
    rd(IRS_IDX_EVT_STATUS);
    chk("second and repeat events", q, 32'h6);
    chk("direct output", direct_buffer_mode, 1'b1);
    pulse(10'h018);
    @(negedge pclk);
    chk("error code length", expected_rx_len, 12'h029);
    @(posedge pclk);
    pulse(10'h020);
    rd(IRS_IDX_STATUS_TWO);
    chk("short reception flag", q, 32'h2);
    $display("rx test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole-run limit against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    t_events;
    t_fifo;
    t_length;
    t_rx;
    close_out;
  end
endmodule
bind irs_regs irs_regs_asserts u_chk (.*);
